// [rtl/cps_pkg.sv]
`default_nettype none
package cps_pkg;
    localparam int CPS_NUM_CORES = 4;
    localparam int CPS_CMD_W     = 3;
    // controller commands
    localparam logic [2:0] CPS_CMD_NONE      = 3'h0;
    localparam logic [2:0] CPS_CMD_CORE_DOWN = 3'h1;
    localparam logic [2:0] CPS_CMD_CORE_UP   = 3'h2;
    localparam logic [2:0] CPS_CMD_CLU_DOWN  = 3'h3;
    localparam logic [2:0] CPS_CMD_CLU_UP    = 3'h4;
    localparam logic [2:0] CPS_CMD_DORM_IN   = 3'h5;
    localparam logic [2:0] CPS_CMD_DORM_OUT  = 3'h6;
    // user port register offsets
    localparam logic [3:0] CPS_ADDR_CMD    = 4'h0;
    localparam logic [3:0] CPS_ADDR_STATUS = 4'h4;
    localparam logic [3:0] CPS_ADDR_FLAGS  = 4'h8;
    localparam int CPS_CMD_LSB  = 0;
    localparam int CPS_CORE_LSB = 4;
    localparam int CPS_CORE_W   = 2;
    localparam logic [7:0] CPS_SRST_DEFAULT = 8'h00;
endpackage : cps_pkg
`default_nettype wire

// [rtl/cps_link_if.sv]
`default_nettype none
interface cps_link_if #(parameter int N = cps_pkg::CPS_NUM_CORES);
    logic         clk;
    logic         rst_n;
    logic [N-1:0] core_wfi_idle_flag;
    logic [N-1:0] core_wfe_idle_flag;
    logic         shared_cache_idle_flag;
    logic         cluster_signal_event_out;
    logic         external_wake_event_in;
    logic [N-1:0] debug_powered_up;
    logic [N-1:0] core_poweron_reset_n;
    logic [N-1:0] level1_hw_reset_bypass;
    logic         shared_cache_reset_n;
    logic         shared_cache_hw_reset_bypass;
    logic         master_port_inactive_req;
    logic [N-1:0] core_clamp;
    logic         cluster_clamp;
    logic         ram_clamp;
    logic [N-1:0] core_supply_on;
    logic         scu_supply_on;
    logic         ram_supply_on;
    logic [N-1:0] core_power_good;
    logic         scu_power_good;
    logic         ram_power_good;
    modport cluster (
        input  clk, rst_n, external_wake_event_in, debug_powered_up, core_poweron_reset_n,
               level1_hw_reset_bypass, shared_cache_reset_n, shared_cache_hw_reset_bypass,
               master_port_inactive_req, core_clamp, cluster_clamp, ram_clamp,
               core_supply_on, scu_supply_on, ram_supply_on,
        output core_wfi_idle_flag, core_wfe_idle_flag, shared_cache_idle_flag,
               cluster_signal_event_out
    );
    modport controller (
        input  clk, rst_n, core_wfi_idle_flag, core_wfe_idle_flag, shared_cache_idle_flag,
               cluster_signal_event_out, core_power_good, scu_power_good, ram_power_good,
        output external_wake_event_in, debug_powered_up, core_poweron_reset_n,
               level1_hw_reset_bypass, shared_cache_reset_n, shared_cache_hw_reset_bypass,
               master_port_inactive_req, core_clamp, cluster_clamp, ram_clamp,
               core_supply_on, scu_supply_on, ram_supply_on
    );
endinterface : cps_link_if
`default_nettype wire

// [rtl/cps_cluster_end.sv]
`default_nettype none
// cluster-side standby and event logic; core activity is modelled by user inputs
module cps_cluster_end #(
    parameter int N    = cps_pkg::CPS_NUM_CORES,
    parameter int OT_W = 4
) (
    cps_link_if.cluster        lnk,
    input  wire logic [N-1:0]  i_wfi_instr,      // core executes wait_for_interrupt_instr
    input  wire logic [N-1:0]  i_wfe_instr,      // core executes wait_for_event_instr
    input  wire logic [N-1:0]  i_sev_instr,      // core executes send_event_instr
    input  wire logic [N-1:0]  i_wake_irq,       // interrupt or debug wake per core
    input  wire logic          i_txn_start,      // bus transaction issued
    input  wire logic          i_txn_done,       // bus transaction completed
    input  wire logic [N-1:0]  i_dbg_req,        // external debug request per core
    output logic [N-1:0]       o_dbg_grant,
    output logic [N-1:0]       o_core_event      // event seen by each core
);
    typedef struct packed {
        logic [N-1:0]    wait_for_interrupt_instr;
        logic [N-1:0]    wait_for_event_instr;
        logic            l2_idle;
        logic            evo;
        logic [N-1:0]    ev;
        logic [N-1:0]    dbg;
        logic [OT_W-1:0] ot;
        logic [1:0]      evi_sync;
        logic            sev_prev;
    } cps_cl_state_t;

    cps_cl_state_t s_reg, s_next;
    logic          evi_s;
    logic          any_sev;

    // core-side ports are logic on the same clock except the event pin
    assign evi_s   = s_reg.evi_sync[1];
    assign any_sev = |i_sev_instr;

    // next-state of standby, event and drain tracking
    always_comb begin
        s_next          = s_reg;
        s_next.evi_sync = {s_reg.evi_sync[0], lnk.external_wake_event_in};
        s_next.sev_prev = any_sev;
        s_next.evo      = any_sev && !s_reg.sev_prev;
        s_next.ev       = {N{evi_s || any_sev}};
        for (int i = 0; i < N; i++) begin
            if (i_wake_irq[i]) begin
                s_next.wait_for_interrupt_instr[i] = 1'b0;
            end else if (i_wfi_instr[i]) begin
                s_next.wait_for_interrupt_instr[i] = 1'b1;
            end
            if (i_wake_irq[i] || evi_s || any_sev) begin
                s_next.wait_for_event_instr[i] = 1'b0;
            end else if (i_wfe_instr[i]) begin
                s_next.wait_for_event_instr[i] = 1'b1;
            end
            // debug only while the controller says the core is powered up
            s_next.dbg[i] = i_dbg_req[i] && lnk.debug_powered_up[i];
        end
        // outstanding counter; the drain must finish before idle is shown
        if (i_txn_start && !i_txn_done && s_reg.ot != {OT_W{1'b1}}) begin
            s_next.ot = s_reg.ot + 1'b1;
        end else if (!i_txn_start && i_txn_done && s_reg.ot != '0) begin
            s_next.ot = s_reg.ot - 1'b1;
        end
        s_next.l2_idle = lnk.master_port_inactive_req && (&s_reg.wait_for_interrupt_instr)
                         && (s_reg.ot == '0) && !(|i_wake_irq);
    end

    // single state register, synchronous reset
    always_ff @(posedge lnk.clk) begin
        if (!lnk.rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign lnk.core_wfi_idle_flag       = s_reg.wait_for_interrupt_instr;
    assign lnk.core_wfe_idle_flag       = s_reg.wait_for_event_instr;
    assign lnk.shared_cache_idle_flag   = s_reg.l2_idle;
    assign lnk.cluster_signal_event_out = s_reg.evo;
    assign o_dbg_grant                  = s_reg.dbg;
    assign o_core_event                 = s_reg.ev;
endmodule : cps_cluster_end
`default_nettype wire

// [rtl/cps_ctrl_end.sv]
`default_nettype none
// power management controller: commands via a small register port
module cps_ctrl_end #(
    parameter int N = cps_pkg::CPS_NUM_CORES
) (
    cps_link_if.controller lnk,
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_event,     // request an external wake event
    output logic [7:0]       o_rdata,
    output logic             o_busy
);
    typedef enum logic [7:0] {
        CPS_IDLE  = 8'h01, CPS_WAITI = 8'h02, CPS_STEP1 = 8'h04, CPS_STEP2 = 8'h08,
        CPS_STEP3 = 8'h10, CPS_STEP4 = 8'h20, CPS_STEP5 = 8'h40, CPS_DONE  = 8'h80
    } cps_st_t;

    typedef struct packed {
        cps_st_t      st;
        logic [2:0]   cmd;
        logic [1:0]   core;
        logic [N-1:0] dbg, por_n, l1byp, clamp, sup;
        logic         l2rst_n, l2byp, inact, cclamp, rclamp, ssup, rsup;
        logic         evi;
        logic [7:0]   rdata;
        logic [N-1:0] wfi_s1, wfi_s2;
        logic         l2i_s1, l2i_s2, pgs_s1, pgs_s2, pgr_s1, pgr_s2;
        logic [N-1:0] pgc_s1, pgc_s2;
        logic         busy;
    } cps_ct_state_t;

    cps_ct_state_t s_reg, s_next;
    logic [N-1:0]  sel;
    logic [N-1:0]  nonlead;
    logic          core_pg_ok;

    function automatic logic [N-1:0] onehot(input logic [1:0] idx);
        onehot = '0;
        onehot[idx] = 1'b1;
    endfunction : onehot

    assign sel        = onehot(s_reg.core);
    assign nonlead    = ~onehot(2'h0);
    assign core_pg_ok = (s_reg.pgc_s2 & sel) == sel;

    always_comb begin
        s_next        = s_reg;
        // two flops on the wfi, cache idle and power-good flags arriving from the cluster and supplies
        s_next.wfi_s1 = lnk.core_wfi_idle_flag;
        s_next.wfi_s2 = s_reg.wfi_s1;
        s_next.l2i_s1 = lnk.shared_cache_idle_flag;
        s_next.l2i_s2 = s_reg.l2i_s1;
        s_next.pgc_s1 = lnk.core_power_good;
        s_next.pgc_s2 = s_reg.pgc_s1;
        s_next.pgs_s1 = lnk.scu_power_good;
        s_next.pgs_s2 = s_reg.pgs_s1;
        s_next.pgr_s1 = lnk.ram_power_good;
        s_next.pgr_s2 = s_reg.pgr_s1;
        s_next.evi    = i_event;
        s_next.rdata  = '0;
        if (i_rd) begin
            case (i_addr)
                cps_pkg::CPS_ADDR_STATUS: s_next.rdata = s_reg.st;
                cps_pkg::CPS_ADDR_FLAGS:  s_next.rdata = {3'h0, s_reg.l2i_s2, s_reg.wfi_s2};
                cps_pkg::CPS_ADDR_CMD:    s_next.rdata = {2'h0, s_reg.core, 1'b0, s_reg.cmd};
                default:                  s_next.rdata = '0;
            endcase
        end
        case (s_reg.st)
            CPS_IDLE: begin
                if (i_wr && i_addr == cps_pkg::CPS_ADDR_CMD
                        && i_wdata[cps_pkg::CPS_CMD_LSB +: cps_pkg::CPS_CMD_W]
                           != cps_pkg::CPS_CMD_NONE) begin
                    s_next.cmd  = i_wdata[cps_pkg::CPS_CMD_LSB +: cps_pkg::CPS_CMD_W];
                    s_next.core = i_wdata[cps_pkg::CPS_CORE_LSB +: cps_pkg::CPS_CORE_W];
                    s_next.st   = CPS_WAITI;
                end
            end
            CPS_WAITI: begin
                case (s_reg.cmd)
                    cps_pkg::CPS_CMD_CORE_DOWN:
                        if (s_reg.wfi_s2[s_reg.core]) s_next.st = CPS_STEP1;
                    cps_pkg::CPS_CMD_CLU_DOWN:
                        // non-lead cores must already be off
                        if ((s_reg.sup & nonlead) == '0 && s_reg.wfi_s2[0]) begin
                            s_next.st = CPS_STEP1;
                        end
                    cps_pkg::CPS_CMD_DORM_IN:
                        if (&s_reg.wfi_s2) s_next.st = CPS_STEP1;
                    default: s_next.st = CPS_STEP1;
                endcase
            end
            CPS_STEP1: begin
                s_next.st = CPS_STEP2;
                case (s_reg.cmd)
                    cps_pkg::CPS_CMD_CORE_DOWN: s_next.dbg = s_reg.dbg & ~sel;
                    cps_pkg::CPS_CMD_CORE_UP: begin
                        s_next.por_n = s_reg.por_n & ~sel;
                        s_next.l1byp = s_reg.l1byp & ~sel;
                        s_next.dbg   = s_reg.dbg & ~sel;
                    end
                    cps_pkg::CPS_CMD_CLU_DOWN: s_next.dbg = '0;
                    cps_pkg::CPS_CMD_DORM_IN: s_next.inact = 1'b1;
                    cps_pkg::CPS_CMD_CLU_UP: begin
                        s_next.por_n = '0;
                        s_next.l1byp = '0;
                        s_next.l2rst_n = 1'b0;
                        s_next.l2byp = 1'b0;
                    end
                    default: begin
                        s_next.por_n = '0;
                        s_next.l2rst_n = 1'b0;
                        s_next.l2byp = 1'b1;
                    end
                endcase
            end
            CPS_STEP2: begin
                s_next.st = CPS_STEP3;
                case (s_reg.cmd)
                    cps_pkg::CPS_CMD_CORE_DOWN: s_next.clamp = s_reg.clamp | sel;
                    cps_pkg::CPS_CMD_CORE_UP:   s_next.sup = s_reg.sup | sel;
                    // lead core clamps only after its debug fence has landed
                    cps_pkg::CPS_CMD_CLU_DOWN: begin
                        s_next.clamp = '1;
                        s_next.inact = 1'b1;
                        if (!s_reg.l2i_s2) s_next.st = CPS_STEP2;
                    end
                    cps_pkg::CPS_CMD_DORM_IN:
                        if (!s_reg.l2i_s2) s_next.st = CPS_STEP2;
                    default: begin
                        s_next.sup  = '1;
                        s_next.ssup = 1'b1;
                        s_next.rsup = 1'b1;
                    end
                endcase
            end
            CPS_STEP3: begin
                s_next.st = CPS_STEP4;
                case (s_reg.cmd)
                    cps_pkg::CPS_CMD_CORE_DOWN: s_next.sup = s_reg.sup & ~sel;
                    cps_pkg::CPS_CMD_CORE_UP:
                        if (core_pg_ok) s_next.clamp = s_reg.clamp & ~sel;
                        else s_next.st = CPS_STEP3;
                    cps_pkg::CPS_CMD_CLU_DOWN: s_next.cclamp = 1'b1;
                    cps_pkg::CPS_CMD_DORM_IN:  s_next.rclamp = 1'b1;
                    default:
                        if ((&s_reg.pgc_s2) && s_reg.pgs_s2 && s_reg.pgr_s2) begin
                            s_next.clamp  = '0;
                            s_next.cclamp = 1'b0;
                            s_next.rclamp = 1'b0;
                        end else begin
                            s_next.st = CPS_STEP3;
                        end
                endcase
            end
            CPS_STEP4: begin
                s_next.st = CPS_STEP5;
                case (s_reg.cmd)
                    cps_pkg::CPS_CMD_CLU_DOWN: begin
                        s_next.sup  = '0;
                        s_next.ssup = 1'b0;
                        s_next.rsup = 1'b0;
                    end
                    cps_pkg::CPS_CMD_DORM_IN: begin
                        s_next.sup  = '0;
                        s_next.ssup = 1'b0;
                    end
                    cps_pkg::CPS_CMD_CORE_UP: s_next.por_n = s_reg.por_n | sel;
                    cps_pkg::CPS_CMD_CORE_DOWN: ;
                    default: begin
                        s_next.por_n   = '1;
                        s_next.l2rst_n = 1'b1;
                    end
                endcase
            end
            CPS_STEP5: begin
                s_next.st = CPS_DONE;
                if (s_reg.cmd == cps_pkg::CPS_CMD_CORE_UP) begin
                    s_next.dbg = s_reg.dbg | sel;
                end else if (s_reg.cmd == cps_pkg::CPS_CMD_CLU_UP
                        || s_reg.cmd == cps_pkg::CPS_CMD_DORM_OUT) begin
                    s_next.dbg = '1;
                    if (!s_reg.l2i_s2) s_next.inact = 1'b0;
                    else s_next.st = CPS_STEP5;
                end
            end
            CPS_DONE: s_next.st = CPS_IDLE;
            default:  s_next.st = CPS_IDLE;
        endcase
        // busy is registered so the status output comes straight from a flop
        s_next.busy = s_next.st != CPS_IDLE;
    end

    // run state after reset: everything powered, unclamped, debug allowed
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            s_reg         <= '0;
            s_reg.st      <= CPS_IDLE;
            s_reg.dbg     <= '1;
            s_reg.por_n   <= '1;
            s_reg.sup     <= '1;
            s_reg.l2rst_n <= 1'b1;
            s_reg.ssup    <= 1'b1;
            s_reg.rsup    <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign lnk.external_wake_event_in       = s_reg.evi;
    assign lnk.debug_powered_up             = s_reg.dbg;
    assign lnk.core_poweron_reset_n         = s_reg.por_n;
    assign lnk.level1_hw_reset_bypass       = s_reg.l1byp;
    assign lnk.shared_cache_reset_n         = s_reg.l2rst_n;
    assign lnk.shared_cache_hw_reset_bypass = s_reg.l2byp;
    assign lnk.master_port_inactive_req     = s_reg.inact;
    assign lnk.core_clamp                   = s_reg.clamp;
    assign lnk.cluster_clamp                = s_reg.cclamp;
    assign lnk.ram_clamp                    = s_reg.rclamp;
    assign lnk.core_supply_on               = s_reg.sup;
    assign lnk.scu_supply_on                = s_reg.ssup;
    assign lnk.ram_supply_on                = s_reg.rsup;
    assign o_rdata                          = s_reg.rdata;
    assign o_busy                           = s_reg.busy;
endmodule : cps_ctrl_end
`default_nettype wire

// [tb/cps_link_properties.sv]
`default_nettype none
// watches the link between the two ends; sees only interface signals
module cps_link_properties #(
    parameter int N = 4
) (
    input wire logic         clk,
    input wire logic         rst_n,
    input wire logic [N-1:0] core_wfi_idle_flag,
    input wire logic         shared_cache_idle_flag,
    input wire logic         cluster_signal_event_out,
    input wire logic [N-1:0] debug_powered_up,
    input wire logic [N-1:0] core_poweron_reset_n,
    input wire logic [N-1:0] level1_hw_reset_bypass,
    input wire logic         shared_cache_reset_n,
    input wire logic         shared_cache_hw_reset_bypass,
    input wire logic         master_port_inactive_req,
    input wire logic [N-1:0] core_clamp,
    input wire logic         cluster_clamp,
    input wire logic         ram_clamp,
    input wire logic [N-1:0] core_supply_on,
    input wire logic         scu_supply_on,
    input wire logic         ram_supply_on
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // core supply drops: idle core, and outside dormant already fenced and clamped
    property p_off_idle;
        ($past(core_supply_on) & ~core_supply_on & ~core_wfi_idle_flag) == '0;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("supply cut on busy core");
    property p_off_order;
        !ram_clamp |-> ($past(core_supply_on) & ~core_supply_on
            & ~($past(core_clamp) & ~$past(debug_powered_up))) == '0;
    endproperty
    a_off_order: assert property (p_off_order) else $error("supply cut before fence");
    // single core power-up: scu stays on, so the cluster sequences are excluded
    property p_up_low;
        $past(scu_supply_on) |-> (~$past(core_supply_on) & core_supply_on
            & (core_poweron_reset_n | level1_hw_reset_bypass | debug_powered_up)) == '0;
    endproperty
    a_up_low: assert property (p_up_low) else $error("core powered with lines high");
    property p_dbg_up;
        (~$past(debug_powered_up) & debug_powered_up
            & (core_clamp | ~core_poweron_reset_n | ~core_supply_on)) == '0;
    endproperty
    a_dbg_up: assert property (p_dbg_up) else $error("debug raised too early");
    property p_clu_off;
        $fell(scu_supply_on) && !ram_clamp
            |-> master_port_inactive_req && cluster_clamp && shared_cache_idle_flag;
    endproperty
    a_clu_off: assert property (p_clu_off) else $error("cluster cut out of order");
    property p_scu_up;
        $rose(scu_supply_on) |-> !shared_cache_reset_n && core_poweron_reset_n == '0
            && level1_hw_reset_bypass == '0;
    endproperty
    a_scu_up: assert property (p_scu_up) else $error("cluster powered out of reset");
    property p_l2_idle;
        $rose(shared_cache_idle_flag) |-> $past(master_port_inactive_req);
    endproperty
    a_l2_idle: assert property (p_l2_idle) else $error("cache idle without request");
    property p_dorm_in;
        $rose(ram_clamp) |-> (&core_wfi_idle_flag) && shared_cache_idle_flag && ram_supply_on;
    endproperty
    a_dorm_in: assert property (p_dorm_in) else $error("ram clamped while not idle");
    property p_unclamp;
        $fell(ram_clamp) |-> scu_supply_on && shared_cache_hw_reset_bypass;
    endproperty
    a_unclamp: assert property (p_unclamp) else $error("ram unclamped too early");
    property p_evo; cluster_signal_event_out |=> !cluster_signal_event_out; endproperty
    a_evo: assert property (p_evo) else $error("event out longer than one cycle");
    property p_inact; $fell(master_port_inactive_req) |-> !shared_cache_idle_flag; endproperty
    a_inact: assert property (p_inact) else $error("inactive dropped while cache idle");
endmodule : cps_link_properties
`default_nettype wire

// [tb/test_cluster_power_sequencer.sv]
`default_nettype none
module test_cluster_power_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk;
    logic       rst_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr, rd, evt, busy, txn_start, txn_done;
    logic [7:0] rdata;
    logic [3:0] wait_for_interrupt_instr, wait_for_event_instr, send_event_instr, wake, dbg_req, dbg_grant, core_event;
    int         n_fail = 0, tests_run = 0, cycles = 0, evo_cnt = 0;

    cps_link_if #(.N(4)) lnk ();
    assign lnk.clk = sys_clk;
    assign lnk.rst_n = rst_n;
    cps_cluster_end i_cps_cluster_end (.lnk(lnk), .i_wfi_instr(wait_for_interrupt_instr), .i_wfe_instr(wait_for_event_instr),
        .i_sev_instr(send_event_instr), .i_wake_irq(wake), .i_txn_start(txn_start), .i_txn_done(txn_done),
        .i_dbg_req(dbg_req), .o_dbg_grant(dbg_grant), .o_core_event(core_event));
    cps_ctrl_end i_cps_ctrl_end (.lnk(lnk), .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_event(evt), .o_rdata(rdata), .o_busy(busy));
    cps_link_properties #(.N(4)) i_cps_link_properties (.clk(lnk.clk), .rst_n(lnk.rst_n),
        .core_wfi_idle_flag(lnk.core_wfi_idle_flag),
        .shared_cache_idle_flag(lnk.shared_cache_idle_flag),
        .cluster_signal_event_out(lnk.cluster_signal_event_out),
        .debug_powered_up(lnk.debug_powered_up),
        .core_poweron_reset_n(lnk.core_poweron_reset_n),
        .level1_hw_reset_bypass(lnk.level1_hw_reset_bypass),
        .shared_cache_reset_n(lnk.shared_cache_reset_n), .core_clamp(lnk.core_clamp),
        .shared_cache_hw_reset_bypass(lnk.shared_cache_hw_reset_bypass), .ram_clamp(lnk.ram_clamp),
        .master_port_inactive_req(lnk.master_port_inactive_req), .cluster_clamp(lnk.cluster_clamp),
        .core_supply_on(lnk.core_supply_on), .scu_supply_on(lnk.scu_supply_on),
        .ram_supply_on(lnk.ram_supply_on));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // supply model reports good one cycle after switch-on; also counts pulses and cycles
    always @(posedge sys_clk) begin
        lnk.core_power_good <= lnk.core_supply_on;
        lnk.scu_power_good <= lnk.scu_supply_on;
        lnk.ram_power_good <= lnk.ram_supply_on;
        evo_cnt <= evo_cnt + int'(lnk.cluster_signal_event_out);
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_chk

    // bounded wait; a hung sequence shows up as busy still high
    task automatic run_cmd(input logic [7:0] d);
        wr_reg(cps_pkg::CPS_ADDR_CMD, d);
        for (int i = 0; i < 400; i++) begin
            @(posedge sys_clk);
            #1;
            if (busy === 1'b0) break;
        end
        chk({7'h0, busy}, 8'h00);
    endtask : run_cmd

    // one-cycle instruction pulses on the cores
    task automatic cores(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c,
                         input logic [3:0] d);
        @(posedge sys_clk);
        {wait_for_interrupt_instr, wait_for_event_instr, send_event_instr, wake} <= {a, b, c, d};
        @(posedge sys_clk);
        {wait_for_interrupt_instr, wait_for_event_instr, send_event_instr, wake} <= 16'h0;
    endtask : cores

    initial begin
        {rst_n, addr, wdata, wr, rd, evt, txn_start, txn_done} = '0;
        {wait_for_interrupt_instr, wait_for_event_instr, send_event_instr, wake, dbg_req} = '0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        // register port, refused command, unmapped place
        rd_chk(cps_pkg::CPS_ADDR_STATUS, 8'h01);
        cores(4'h2, 4'h0, 4'h0, 4'h0);
        repeat (5) @(posedge sys_clk);
        rd_chk(cps_pkg::CPS_ADDR_FLAGS, 8'h02);
        wr_reg(cps_pkg::CPS_ADDR_CMD, 8'h00);
        rd_chk(cps_pkg::CPS_ADDR_STATUS, 8'h01);
        rd_chk(4'hc, 8'h00);
        $display("test registers done");
        // events: send event, external event, interrupt wake
        cores(4'h0, 4'hf, 4'h0, 4'h0);
        repeat (3) @(posedge sys_clk);
        chk({4'h0, lnk.core_wfe_idle_flag}, 8'h0f);
        cores(4'h0, 4'h0, 4'h4, 4'h0);
        #1 chk({4'h0, core_event}, 8'h0f);
        repeat (6) @(posedge sys_clk);
        chk(8'(evo_cnt), 8'h01);
        chk({4'h0, lnk.core_wfe_idle_flag}, 8'h00);
        cores(4'h0, 4'hf, 4'h0, 4'h0);
        evt <= 1'b1;
        @(posedge sys_clk);
        evt <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({4'h0, lnk.core_wfe_idle_flag}, 8'h00);
        cores(4'h0, 4'hf, 4'h0, 4'h1);
        repeat (4) @(posedge sys_clk);
        chk({4'h0, lnk.core_wfe_idle_flag}, 8'h0e);
        $display("test events done");
        // single core down then up, with debug requests pending
        dbg_req <= 4'h2;
        run_cmd(8'h11);
        chk({4'h0, lnk.core_supply_on}, 8'h0d);
        chk({4'h0, lnk.core_clamp}, 8'h02);
        chk({4'h0, dbg_grant & 4'h2}, 8'h00);
        run_cmd(8'h12);
        chk({lnk.core_clamp, lnk.core_poweron_reset_n}, 8'h0f);
        chk({4'h0, lnk.debug_powered_up}, 8'h0f);
        repeat (3) @(posedge sys_clk);
        chk({4'h0, dbg_grant & 4'h2}, 8'h02);
        $display("test core cycle done");
        // cluster down with one transaction outstanding, then up
        cores(4'hf, 4'h0, 4'h0, 4'h0);
        for (int k = 1; k < 4; k++) run_cmd({2'h0, 2'(k), 4'h1});
        @(posedge sys_clk);
        txn_start <= 1'b1;
        @(posedge sys_clk);
        txn_start <= 1'b0;
        wr_reg(cps_pkg::CPS_ADDR_CMD, 8'h03);
        repeat (20) @(posedge sys_clk);
        chk({busy, lnk.shared_cache_idle_flag}, 8'h02);
        txn_done <= 1'b1;
        @(posedge sys_clk);
        txn_done <= 1'b0;
        run_cmd(8'h00);
        chk({lnk.scu_supply_on, lnk.ram_supply_on, lnk.cluster_clamp,
             lnk.master_port_inactive_req}, 8'h03);
        wr_reg(cps_pkg::CPS_ADDR_CMD, 8'h04);
        repeat (10) @(posedge sys_clk);
        cores(4'h0, 4'h0, 4'h0, 4'hf);
        run_cmd(8'h00);
        chk({lnk.scu_supply_on, lnk.ram_supply_on, lnk.cluster_clamp,
             lnk.master_port_inactive_req}, 8'h0c);
        chk({lnk.core_supply_on, lnk.core_poweron_reset_n}, 8'hff);
        $display("test cluster cycle done");
        // dormant retention entry and exit
        cores(4'hf, 4'h0, 4'h0, 4'h0);
        run_cmd(8'h05);
        chk({lnk.core_supply_on, lnk.scu_supply_on, lnk.ram_supply_on, lnk.ram_clamp},
            8'h03);
        wr_reg(cps_pkg::CPS_ADDR_CMD, 8'h06);
        repeat (10) @(posedge sys_clk);
        cores(4'h0, 4'h0, 4'h0, 4'hf);
        run_cmd(8'h00);
        chk({lnk.core_supply_on, lnk.scu_supply_on, lnk.ram_supply_on, lnk.ram_clamp},
            8'h7e);
        rd_chk(cps_pkg::CPS_ADDR_STATUS, 8'h01);
        rd_chk(cps_pkg::CPS_ADDR_CMD, 8'h06);
        $display("test dormant done");
        print_verdict();
    end
endmodule : test_cluster_power_sequencer
`default_nettype wire
